// ==== hdl/qbas_pkg.sv ====
/*
  Package for the quad byte asynchronous memory controller: widths, timing figures, states.
  Assumes a 100 MHz controller clock; times are in ns and converted to cycles here.
*/
package qbas_pkg;
  localparam int ADDR_W       = 19;
  localparam int LANE_W       = 8;
  localparam int LANES        = 4;
  localparam int CLK_NS       = 10;
  localparam int ACCESS_NS    = 17;
  localparam int WPULSE_NS    = 20;
  localparam int FLOAT_NS     = 10;
  localparam int RECOVER_NS   = 10;
  localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam int WPULSE_CYC   = (WPULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLOAT_CYC    = (FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC  = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 4;
  localparam logic [3:0] ALL_OFF_N = 4'hF;

  typedef enum logic [2:0] {
    QBAS_IDLE, QBAS_RD, QBAS_WR_FLOAT, QBAS_WR_PULSE, QBAS_RECOVER
  } qbas_state_e;

  function automatic logic [CNT_W-1:0] qbas_cnt(input int cycles);
    return CNT_W'(cycles < 1 ? 0 : cycles - 1);
  endfunction
endpackage

// ==== hdl/qbas_lane_hold.sv ====
/*
  Read data capture register: holds the 32-bit word sampled from the memory lanes.
  Assumes the capture strobe is issued once the access time has elapsed.
*/
`timescale 1ns/1ns
`default_nettype none
module qbas_lane_hold
  import qbas_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk_i,
  input  wire logic             arst_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q_o <= '0;
    end else if (load_i) begin
      q_o <= d_i;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/qbas_ctrl.sv ====
/*
  Host side controller for a memory module of four byte-wide asynchronous dies.
  Assumes requests and pin inputs are synchronous to mclk_i; a request is taken when
  req_i is high and busy_o low. Byte lanes are chosen by lane_sel_i (active high).
*/
// Behaviour
// - Host ties select and strobe of chosen dies for 8 to 32 bit access
// - With select and drive low, address changes no faster than minimum read cycle
// - Select-started read: host holds address stable for the whole cycle
// - Strobe-ended write: raise strobe with select low, after the minimum pulse width (the code raises select in the same cycle as strobe)
// - Select-ended write: first of select or strobe rising ends it, minimum pulse kept
// - Host waits the float time after strobe falls before driving write data
`timescale 1ns/1ns
`default_nettype none
module qbas_ctrl
  import qbas_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    arst_n_i,
  input  wire logic                    req_i,
  input  wire logic                    we_i,
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [LANES-1:0]        lane_sel_i,
  input  wire logic [LANES*LANE_W-1:0] wdata_i,
  output logic                         busy_o,
  output logic                         rvalid_o,
  output logic      [LANES*LANE_W-1:0] rdata_o,
  output logic      [ADDR_W-1:0]       mem_addr_o,
  output logic      [LANES-1:0]        die_select_n_o,
  output logic      [LANES-1:0]        die_write_n_o,
  output logic                         out_drive_n_o,
  input  wire logic [LANES*LANE_W-1:0] dq_i,
  output logic      [LANES*LANE_W-1:0] dq_o,
  output logic      [LANES-1:0]        dq_oe_n_o
);
  qbas_state_e             state;
  logic        [CNT_W-1:0] cnt;
  logic                    cap;
  logic        [LANES-1:0] lanes;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= QBAS_IDLE;
      cnt   <= '0;
    end else begin
      unique case (state)
        QBAS_IDLE: begin
          if (req_i && !busy_o) begin
            state <= we_i ? QBAS_WR_FLOAT : QBAS_RD;
            cnt   <= we_i ? qbas_cnt(FLOAT_CYC) : qbas_cnt(ACCESS_CYC);
          end
        end
        QBAS_RD: begin
          if (cnt == '0) begin
            state <= QBAS_RECOVER;
            cnt   <= qbas_cnt(RECOVER_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        QBAS_WR_FLOAT: begin
          if (cnt == '0) begin
            state <= QBAS_WR_PULSE;
            cnt   <= qbas_cnt(WPULSE_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        QBAS_WR_PULSE: begin
          if (cnt == '0) begin
            state <= QBAS_RECOVER;
            cnt   <= qbas_cnt(RECOVER_CYC);
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        QBAS_RECOVER: begin
          if (cnt == '0) begin
            state <= QBAS_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end

  // Request capture: address, lanes and data held for the whole access
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_addr_o <= '0;
      lanes      <= '0;
      dq_o       <= '0;
    end else if (state == QBAS_IDLE && req_i && !busy_o) begin
      mem_addr_o <= addr_i;
      lanes      <= lane_sel_i;
      dq_o       <= wdata_i;
    end
  end

  // Pin strobes
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      die_select_n_o <= ALL_OFF_N;
      die_write_n_o  <= ALL_OFF_N;
      out_drive_n_o  <= 1'b1;
      dq_oe_n_o      <= ALL_OFF_N;
      busy_o         <= 1'b0;
    end else begin
      busy_o <= !(state == QBAS_IDLE && !(req_i && !busy_o)) &&
                !(state == QBAS_RECOVER && cnt == '0);
      if (state == QBAS_IDLE && req_i && !busy_o) begin
        die_select_n_o <= ~lane_sel_i;
        die_write_n_o  <= we_i ? ~lane_sel_i : ALL_OFF_N;
        out_drive_n_o  <= we_i;
        dq_oe_n_o      <= ALL_OFF_N;
      end else if (state == QBAS_WR_FLOAT && cnt == '0) begin
        dq_oe_n_o <= ~lanes;
      end else if ((state == QBAS_WR_PULSE || state == QBAS_RD) && cnt == '0) begin
        die_select_n_o <= ALL_OFF_N;
        die_write_n_o  <= ALL_OFF_N;
        out_drive_n_o  <= 1'b1;
      end else if (state == QBAS_RECOVER && cnt == '0) begin
        dq_oe_n_o <= ALL_OFF_N;
      end
    end
  end

  assign cap = (state == QBAS_RD) && (cnt == '0);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= cap;
    end
  end

  qbas_lane_hold #(.WIDTH(LANES*LANE_W)) u_hold (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .load_i   (cap),
    .d_i      (dq_i),
    .q_o      (rdata_o)
  );

  // Access timing and pin checks
  chk_write_float_guard: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(die_write_n_o[0]) |-> dq_oe_n_o[0])
    else $error("write data driven before float time");
  chk_no_drive_read: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !out_drive_n_o |-> &dq_oe_n_o)
    else $error("host drives lanes during read");
  chk_read_access: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(out_drive_n_o) |-> ##3 rvalid_o)
    else $error("read data not captured after access time");
  chk_addr_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (die_select_n_o != ALL_OFF_N) |=> $stable(mem_addr_o) || die_select_n_o == ALL_OFF_N)
    else $error("address moved during access");
  chk_pulse_width: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(dq_oe_n_o[0]) |-> !die_write_n_o[0] [*2])
    else $error("write pulse too short");
  chk_data_hold: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(die_write_n_o[0]) |-> !dq_oe_n_o[0] && $stable(dq_o))
    else $error("write data released before strobe end");
  chk_write_end: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(die_write_n_o[0]) |-> $rose(die_select_n_o[0]))
    else $error("write not ended by select and strobe");
  chk_lane_match: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    (die_write_n_o | die_select_n_o) == die_write_n_o)
    else $error("strobe without select");
  chk_float_then_drive: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(die_write_n_o[0]) |=> !dq_oe_n_o[0])
    else $error("write data not driven after float time");
  chk_strobe_pair: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(die_write_n_o[0]) |-> $fell(die_select_n_o[0]))
    else $error("write strobe fell without select");
  chk_data_stable: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !(&dq_oe_n_o) |=> $stable(dq_o) || &dq_oe_n_o)
    else $error("write data moved while driven");
  chk_busy_span: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(busy_o) |-> busy_o [*4] ##1 !busy_o)
    else $error("access length wrong");
  chk_drive_span: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $fell(out_drive_n_o) |-> !out_drive_n_o [*3] ##1 out_drive_n_o)
    else $error("output drive window wrong");
  chk_rvalid_pulse: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    rvalid_o |=> !rvalid_o)
    else $error("read valid longer than one cycle");
  chk_capture_read: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    cap |-> !out_drive_n_o && die_write_n_o == ALL_OFF_N)
    else $error("capture outside a read");
  chk_write_no_drive: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !(&die_write_n_o) |-> out_drive_n_o)
    else $error("output drive low during write");
  chk_read_no_strobe: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !out_drive_n_o |-> die_write_n_o == ALL_OFF_N)
    else $error("write strobe low during read");
  chk_idle_released: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    !busy_o |-> die_select_n_o == ALL_OFF_N && out_drive_n_o && &dq_oe_n_o)
    else $error("pins not released while idle");

  // Main scenario covers
  cov_read: cover property (@(posedge mclk_i) disable iff (!arst_n_i) rvalid_o);
  cov_write: cover property (@(posedge mclk_i) disable iff (!arst_n_i) $rose(die_write_n_o[0]));
  cov_full_word: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    die_select_n_o == 4'h0);
  cov_byte_lane: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    die_select_n_o == 4'h7);
  cov_two_lanes: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    die_select_n_o == 4'hC);
endmodule
`default_nettype wire

// ==== verification/qbas_mem_model.sv ====
/*
  Behavioural model of the four-die asynchronous byte memory.
  Assumes it alone resolves the data wire from both parties' enables.
*/
`timescale 1ns/1ns
`default_nettype none
module qbas_mem_model
  import qbas_pkg::*;
(
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic [LANES-1:0]        select_n_i,
  input  wire logic [LANES-1:0]        write_n_i,
  input  wire logic                    drive_n_i,
  input  wire logic [LANES*LANE_W-1:0] host_dq_i,
  input  wire logic [LANES-1:0]        host_oe_n_i,
  output logic      [LANES*LANE_W-1:0] wire_dq_o = '0,
  output logic                         fault_o = 1'b0
);
  logic [7:0]        mem [int];
  logic [ADDR_W-1:0] wa [LANES];
  logic [LANES-1:0]  wr_q = '0;
  realtime           t_chg = 0;
  logic              ok;
  always @(addr_i or select_n_i or drive_n_i) t_chg = $realtime;
  always #1 begin : poll
    int   k;
    logic a, h, d;
    ok = ($realtime - t_chg >= ACCESS_NS);
    for (int l = 0; l < LANES; l++) begin
      k = (l << ADDR_W) + addr_i;
      a = !select_n_i[l] && !write_n_i[l];
      h = !host_oe_n_i[l];
      d = !select_n_i[l] && write_n_i[l] && !drive_n_i;
      if (h && d) fault_o = 1'b1;
      if (wr_q[l] && a && addr_i !== wa[l]) fault_o = 1'b1;
      if (wr_q[l] && !a) mem[(l << ADDR_W) + wa[l]] = wire_dq_o[8*l+:8];
      if (a && !wr_q[l]) wa[l] = addr_i;
      wr_q[l] = a;
      wire_dq_o[8*l+:8] = h ? host_dq_i[8*l+:8] : (d && ok) ?
        (mem.exists(k) ? mem[k] : 8'h5A) : ~wire_dq_o[8*l+:8];
    end
  end
endmodule
`default_nettype wire

// ==== verification/quad_byte_async_sram_tb.sv ====
/*
  Self-checking bench for the quad byte memory controller.
  Assumes the memory model on the far side of the pins.
*/
`timescale 1ns/1ns
`default_nettype none
module quad_byte_async_sram_tb;
  import qbas_pkg::*;
  logic        mclk_i, arst_n_i, req, we, busy, rvalid, drive_n, fault;
  logic [18:0] addr, mem_addr;
  logic [3:0]  lane, sel_n, wr_n, oe_n;
  logic [31:0] wdata, rdata, dq_i, dq_o;
  int          mismatches = 0, comparisons = 0;

  qbas_ctrl dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .req_i(req), .we_i(we),
    .addr_i(addr), .lane_sel_i(lane), .wdata_i(wdata), .busy_o(busy), .rvalid_o(rvalid),
    .rdata_o(rdata), .mem_addr_o(mem_addr), .die_select_n_o(sel_n), .die_write_n_o(wr_n),
    .out_drive_n_o(drive_n), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(oe_n));
  qbas_mem_model mem_u (.addr_i(mem_addr), .select_n_i(sel_n), .write_n_i(wr_n),
    .drive_n_i(drive_n), .host_dq_i(dq_o), .host_oe_n_i(oe_n), .wire_dq_o(dq_i),
    .fault_o(fault));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic print_verdict();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [18:0] a, input logic [3:0] l,
                      input logic [31:0] d, output logic [31:0] q);
    logic seen;
    int   n_v;
    int   n_b;
    @(posedge mclk_i);
    req <= 1'b1; we <= w; addr <= a; lane <= l; wdata <= d;
    @(posedge mclk_i);
    req <= 1'b0;
    q = 'x;
    seen = 1'b0;
    n_v = -1;
    n_b = -1;
    for (int n = 0; n < 30; n++) begin
      @(negedge mclk_i);
      if (rvalid === 1'b1) begin
        q = rdata;
        n_v = n;
      end
      if (busy === 1'b1) begin
        seen = 1'b1;
      end else if (seen) begin
        n_b = n;
        break;
      end
    end
    check({31'h0, seen}, 32'h1);
    check({31'h0, busy}, 32'h0);
    check(n_v, w ? -1 : ACCESS_CYC);
    check(n_b, w ? FLOAT_CYC + WPULSE_CYC + RECOVER_CYC : ACCESS_CYC + RECOVER_CYC);
  endtask
  task automatic t_full();
    logic [31:0] q;
    xfer(1'b1, 19'h00000, 4'hF, 32'h1234ABCD, q);
    xfer(1'b1, 19'h7FFFF, 4'hF, 32'hC0FFEE01, q);
    xfer(1'b0, 19'h00000, 4'hF, 32'h0, q);
    check(q, 32'h1234ABCD);
    xfer(1'b0, 19'h7FFFF, 4'hF, 32'h0, q);
    check(q, 32'hC0FFEE01);
  endtask
  task automatic t_lanes();
    logic [31:0] q;
    for (int i = 1; i < 5; i++) begin
      xfer(1'b1, 19'h00055, 4'hF, 32'h0, q);
      xfer(1'b1, 19'h00055, 4'(2**i - 1), 32'hA5C3965A, q);
      xfer(1'b0, 19'h00055, 4'hF, 32'h0, q);
      check(q, 32'hA5C3965A & (32'hFFFFFFFF >> (8 * (4 - i))));
    end
  endtask
  task automatic t_pins();
    logic [31:0] q;
    xfer(1'b1, 19'h2AAAA, 4'h8, 32'h7E000000, q);
    xfer(1'b0, 19'h2AAAA, 4'h8, 32'h0, q);
    check(q & 32'hFF000000, 32'h7E000000);
    check({sel_n, wr_n, oe_n, 19'h0, drive_n}, 32'hFFF00001);
    check({31'h0, fault}, 32'h0);
  endtask
  initial begin
    arst_n_i = 1'b0; req = 1'b0; we = 1'b0; addr = '0; lane = '0; wdata = '0;
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_full();
    t_lanes();
    t_pins();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
